// [core/xcmwa_regs.vh]
// Register offsets, field positions, reset values and code-group constants
`ifndef XCMWA_REGS_VH
`define XCMWA_REGS_VH

// APB register byte offsets
`define XCMWA_CTRL_OFF 12'h000
`define XCMWA_STAT_OFF 12'h004

// Control register fields
`define XCMWA_CTRL_COMMA_LSB 0
`define XCMWA_CTRL_COMMA_MSB 9
`define XCMWA_CTRL_IDLE_BIT 16
`define XCMWA_COMMA_RST 10'h0FA
`define XCMWA_IDLE_EN_RST 1'b1

// Status register fields
`define XCMWA_STAT_LOCK_LSB 0
`define XCMWA_STAT_ARMED_LSB 8
`define XCMWA_STAT_SIGDET_LSB 12

// XGMII characters and special code-group bytes
`define XCMWA_XG_IDLE 8'h07
`define XCMWA_XG_SEQ 8'h9C
`define XCMWA_XG_START 8'hFB
`define XCMWA_XG_TERM 8'hFD
`define XCMWA_XG_ERR 8'hFE
`define XCMWA_K28_0 8'h1C
`define XCMWA_K28_3 8'h7C
`define XCMWA_K28_5 8'hBC

// Synchronization and idle generation counts, and the idle LFSR seed
`define XCMWA_SYNC_COMMAS 3'h4
`define XCMWA_A_GAP_MIN 5'h08
`define XCMWA_LFSR_SEED 7'h7F

`endif

// [core/xcmwa_lane_align.v]
// Per-lane comma pattern detector and word aligner, two code-groups per word
`timescale 1ns/1ps
`default_nettype none

module xcmwa_lane_align #(
	parameter WORD_W = 20
) (
	input wire pclk,
	input wire presetn,
	input wire [WORD_W-1:0] raw_word,
	input wire align_en,
	input wire [9:0] comma_pat,
	output reg [WORD_W-1:0] aligned_word,
	output reg [1:0] comma_seen,
	output reg armed
);

	localparam WIN_W = 2 * WORD_W;

	reg [WORD_W-1:0] prev_reg;
	reg [4:0] off_reg;
	reg en_d_reg;
	wire [WIN_W-1:0] window;
	wire [WIN_W-1:0] shifted;
	wire [WORD_W-1:0] hit;
	wire rise;
	reg found;
	reg [4:0] hit_off;
	integer k;

	// Older word sits in the low bits: low bits were received first
	assign window = {raw_word, prev_reg};
	assign shifted = window >> off_reg;
	assign rise = align_en & ~en_d_reg;

	genvar g;
	generate
		for (g = 0; g < WORD_W; g = g + 1) begin : g_hit
			assign hit[g] = (window[g+9:g] == comma_pat) |
				(window[g+9:g] == ~comma_pat); // R11 R12
		end
	endgenerate

	// Lowest offset wins so a comma is never skipped over
	always @* begin
		found = 1'b0;
		hit_off = 5'h00;
		for (k = WORD_W - 1; k >= 0; k = k - 1) begin
			if (hit[k]) begin
				found = 1'b1;
				hit_off = k[4:0];
			end
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= {WORD_W{1'b0}};
			off_reg <= 5'h00;
			en_d_reg <= 1'b0;
			armed <= 1'b0;
			aligned_word <= {WORD_W{1'b0}};
			comma_seen <= 2'b00;
		end else begin
			prev_reg <= raw_word;
			en_d_reg <= align_en;
			// Boundary only moves after a low-to-high enable; else untouched
			if (rise) begin
				armed <= 1'b1; // R9
			end else if (armed && found) begin
				armed <= 1'b0;
				off_reg <= hit_off; // R21
			end
			aligned_word <= shifted[WORD_W-1:0]; // R9
			comma_seen[0] <= (shifted[9:0] == comma_pat) |
				(shifted[9:0] == ~comma_pat); // R10 R12
			comma_seen[1] <= (shifted[19:10] == comma_pat) |
				(shifted[19:10] == ~comma_pat); // R10 R12
		end
	end

endmodule

`default_nettype wire

// [core/xcmwa_top.v]
// XAUI code mapping, idle generation, word alignment and lane sync
`timescale 1ns/1ps
`default_nettype none
`include "xcmwa_regs.vh"

// Function
// R1: Control flag low: lane byte goes out unchanged as a data code-group.
// R2: Control idle 07 goes out as K28.0, K28.3 or K28.5.
// R3: Idle columns become a pseudorandom mix of A, R and K columns.
// R4: 9C, FB, FD map to K28.4, K27.7, K29.7; others to K30.7.
// R5: Decoded code-groups of four lanes map back to XGMII bytes and flags.
// R6: Ordered sets are four-lane columns starting on lane 0.
// R7: Each lane feeds its own 8B/10B encoder and serial pair.
// R8: Each lane carries two code-group bytes per clock, 16 bits wide.
// R9: Aligner stays in path; without enable edges the boundary never moves.
// R10: Comma seen pulses one cycle per matching word; boundary untouched.
// R11: The comma compared against is a programmable 10-bit pattern.
// R12: Both the comma and its bitwise complement are matched.
// R13: Four K28.5 commas, with valid groups between, give synchronization.
// R14: Partner sends no invalid code-groups while sync is being acquired.
// R15: Locked output rises once synchronization is achieved.
// R16: Acquisition starts only with signal present and reset released.
// R17: Losing signal or entering reset abandons sync and waits again.
// R18: Realignment needs the enable driven low then high.
// R19: High and low byte of each lane have separate locked outputs.
// R20: Locked stays low after abandonment until acquisition completes.
// R21: Realignment puts the found comma in the first code-group slot.
module xcmwa_top (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [63:0] xgmii_txd,
	input wire [7:0] xgmii_txc,
	output reg [63:0] tx_code,
	output reg [7:0] tx_kflag,
	input wire [79:0] rx_raw,
	input wire [3:0] comma_align_en,
	output wire [79:0] rx_aligned,
	output wire [7:0] comma_seen,
	input wire [63:0] rx_dec,
	input wire [7:0] rx_deck,
	input wire [7:0] rx_decerr,
	input wire rx_reset,
	input wire [3:0] sig_detect,
	output reg [63:0] xgmii_rxd,
	output reg [7:0] xgmii_rxc,
	output reg [7:0] lane_locked
);

	localparam ST_LOSS = 3'b001;
	localparam ST_ACQ = 3'b010;
	localparam ST_SYNC = 3'b100;

	reg [9:0] comma_reg;
	reg idle_en_reg;
	reg [3:0] sig_meta_reg;
	reg [3:0] sig_sync_reg;
	reg [6:0] lfsr_reg;
	reg [6:0] lfsr_next;
	reg [4:0] agap_reg;
	reg [4:0] agap_next;
	reg was_idle_reg;
	reg [7:0] idle_lo;
	reg [7:0] idle_hi;
	reg [11:0] st_reg;
	reg [11:0] st_next;
	reg [11:0] cnt_reg;
	reg [11:0] cnt_next;
	wire [3:0] armed;
	wire [63:0] tx_code_next;
	wire [7:0] tx_kflag_next;
	wire [63:0] rxd_next;
	wire [7:0] rxc_next;
	wire col_idle_lo;
	wire col_idle_hi;
	wire apb_acc;
	wire hit_ctrl;
	wire hit_stat;
	integer n;
	integer m;

	// XGMII byte with control flag set, mapped to a special code byte
	function [7:0] map_tx;
		input [7:0] b;
		begin
			case (b)
				`XCMWA_XG_SEQ: map_tx = b; // R4
				`XCMWA_XG_START: map_tx = b; // R4
				`XCMWA_XG_TERM: map_tx = b; // R4
				`XCMWA_XG_IDLE: map_tx = `XCMWA_K28_5; // R2
				default: map_tx = `XCMWA_XG_ERR; // R4
			endcase
		end
	endfunction

	// Decoded code-group to {control, byte}
	function [8:0] map_rx;
		input [7:0] b;
		input k;
		input err;
		begin
			if (err) begin
				map_rx = {1'b1, `XCMWA_XG_ERR};
			end else if (!k) begin
				map_rx = {1'b0, b};
			end else begin
				case (b)
					`XCMWA_K28_0: map_rx = {1'b1, `XCMWA_XG_IDLE};
					`XCMWA_K28_3: map_rx = {1'b1, `XCMWA_XG_IDLE};
					`XCMWA_K28_5: map_rx = {1'b1, `XCMWA_XG_IDLE};
					`XCMWA_XG_SEQ: map_rx = {1'b1, b};
					`XCMWA_XG_START: map_rx = {1'b1, b};
					`XCMWA_XG_TERM: map_rx = {1'b1, b};
					default: map_rx = {1'b1, `XCMWA_XG_ERR};
				endcase
			end
		end
	endfunction

	// Transmit: a column is idle only when all four lanes carry idle
	assign col_idle_lo = (xgmii_txc[3:0] == 4'hF) &&
		(xgmii_txd[31:0] == {4{`XCMWA_XG_IDLE}}) && idle_en_reg; // R6
	assign col_idle_hi = (xgmii_txc[7:4] == 4'hF) &&
		(xgmii_txd[63:32] == {4{`XCMWA_XG_IDLE}}) && idle_en_reg; // R6

	// First idle column after traffic is K, except an upper one after an idle upper column; /A/ is spaced by agap
	always @* begin
		lfsr_next = {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
		agap_next = agap_reg;
		idle_lo = `XCMWA_K28_5;
		idle_hi = `XCMWA_K28_5;
		if (col_idle_lo | col_idle_hi) begin
			if (agap_reg != 5'h00) begin
				agap_next = agap_reg - 5'h01;
			end
		end
		if (col_idle_lo && was_idle_reg) begin
			if (agap_reg == 5'h00) begin
				idle_lo = `XCMWA_K28_3; // R3
				agap_next = `XCMWA_A_GAP_MIN + {2'b00, lfsr_reg[2:0]};
			end else if (lfsr_reg[0]) begin
				idle_lo = `XCMWA_K28_0; // R3
			end
		end
		if (col_idle_hi && (col_idle_lo || was_idle_reg) && lfsr_reg[1]) begin
			idle_hi = `XCMWA_K28_0; // R3
		end
	end

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_byte
			wire [7:0] tb;
			wire col_idle;
			wire [8:0] rm;
			assign tb = xgmii_txd[i*8+:8];
			assign col_idle = (i < 4) ? col_idle_lo : col_idle_hi;
			assign tx_code_next[i*8+:8] = col_idle ?
				((i < 4) ? idle_lo : idle_hi) :
				(xgmii_txc[i] ? map_tx(tb) : tb); // R1 R2 R4
			assign tx_kflag_next[i] = xgmii_txc[i]; // R1
			assign rm = map_rx(rx_dec[i*8+:8], rx_deck[i], rx_decerr[i]);
			assign rxd_next[i*8+:8] = rm[7:0]; // R5
			assign rxc_next[i] = rm[8]; // R5
		end
		for (i = 0; i < 4; i = i + 1) begin : g_lane
			xcmwa_lane_align #(
				.WORD_W(20)
			) u_align (
				.pclk(pclk),
				.presetn(presetn),
				.raw_word(rx_raw[i*20+:20]),
				.align_en(comma_align_en[i]), // R18
				.comma_pat(comma_reg), // R11
				.aligned_word(rx_aligned[i*20+:20]),
				.comma_seen(comma_seen[i*2+:2]),
				.armed(armed[i])
			);
		end
	endgenerate

	// Lane sync: count decoded K28.5 commas; byte slots are lane bytes i, i+4
	always @* begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		for (n = 0; n < 4; n = n + 1) begin
			if (rx_reset || !sig_sync_reg[n]) begin
				st_next[n*3+:3] = ST_LOSS; // R17
				cnt_next[n*3+:3] = 3'h0;
			end else begin
				case (st_reg[n*3+:3])
					ST_LOSS: begin
						st_next[n*3+:3] = ST_ACQ; // R16
						cnt_next[n*3+:3] = 3'h0;
					end
					ST_ACQ: begin
						if (rx_decerr[n] || rx_decerr[n+4]) begin
							// Invalid group here restarts the count
							cnt_next[n*3+:3] = 3'h0; // R14
						end else if ((rx_deck[n] &&
							rx_dec[n*8+:8] == `XCMWA_K28_5) ||
							(rx_deck[n+4] &&
							rx_dec[(n+4)*8+:8] == `XCMWA_K28_5)) begin
							cnt_next[n*3+:3] = cnt_reg[n*3+:3] + 3'h1;
							if (cnt_reg[n*3+:3] + 3'h1 ==
								`XCMWA_SYNC_COMMAS) begin
								st_next[n*3+:3] = ST_SYNC; // R13
							end
						end
					end
					ST_SYNC: st_next[n*3+:3] = ST_SYNC;
					default: st_next[n*3+:3] = ST_LOSS;
				endcase
			end
		end
	end

	assign apb_acc = psel && penable && pready;
	assign hit_ctrl = (paddr == `XCMWA_CTRL_OFF);
	assign hit_stat = (paddr == `XCMWA_STAT_OFF);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comma_reg <= `XCMWA_COMMA_RST;
			idle_en_reg <= `XCMWA_IDLE_EN_RST;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			sig_meta_reg <= 4'h0;
			sig_sync_reg <= 4'h0;
			lfsr_reg <= `XCMWA_LFSR_SEED;
			agap_reg <= `XCMWA_A_GAP_MIN;
			was_idle_reg <= 1'b0;
			tx_code <= 64'h0000000000000000;
			tx_kflag <= 8'h00;
			xgmii_rxd <= 64'h0000000000000000;
			xgmii_rxc <= 8'h00;
			st_reg <= {4{ST_LOSS}};
			cnt_reg <= 12'h000;
			lane_locked <= 8'h00;
		end else begin
			// One wait state: ready rises in the second access cycle
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready &&
				!(hit_ctrl || (hit_stat && !pwrite));
			if (psel && penable && !pready && !pwrite) begin
				if (hit_ctrl) begin
					prdata <= {15'h0000, idle_en_reg, 6'h00, comma_reg};
				end else if (hit_stat) begin
					prdata <= {16'h0000, sig_sync_reg, armed, lane_locked};
				end else begin
					prdata <= 32'h00000000;
				end
			end
			if (apb_acc && pwrite && hit_ctrl) begin
				comma_reg <= pwdata[`XCMWA_CTRL_COMMA_MSB:
					`XCMWA_CTRL_COMMA_LSB]; // R11
				idle_en_reg <= pwdata[`XCMWA_CTRL_IDLE_BIT];
			end
			sig_meta_reg <= sig_detect;
			sig_sync_reg <= sig_meta_reg;
			lfsr_reg <= lfsr_next;
			agap_reg <= agap_next;
			was_idle_reg <= col_idle_hi | (col_idle_lo & ~idle_en_reg);
			// Encoder and serializer per lane sit behind these bytes
			tx_code <= tx_code_next; // R7 R8
			tx_kflag <= tx_kflag_next; // R8
			xgmii_rxd <= rxd_next; // R5
			xgmii_rxc <= rxc_next; // R5
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			// Own index: sharing one with the comb block would race
			for (m = 0; m < 4; m = m + 1) begin
				lane_locked[m] <= (st_next[m*3+:3] == ST_SYNC); // R15 R19 R20
				lane_locked[m+4] <= (st_next[m*3+:3] == ST_SYNC); // R19 R20
			end
		end
	end

endmodule

`default_nettype wire

// [bench/xcmwa_asserts.sv]
// Port assertions for the XAUI code mapper and word aligner
`timescale 1ns/1ps
`default_nettype none
module xcmwa_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [63:0] xgmii_txd,
	input wire logic [7:0] xgmii_txc,
	input wire logic [63:0] tx_code,
	input wire logic [79:0] rx_aligned,
	input wire logic [7:0] comma_seen,
	input wire logic [63:0] rx_dec,
	input wire logic [7:0] rx_deck,
	input wire logic [7:0] rx_decerr,
	input wire logic rx_reset,
	input wire logic [63:0] xgmii_rxd,
	input wire logic [7:0] xgmii_rxc,
	input wire logic [7:0] lane_locked
);
	logic [9:0] pat_reg;
	logic wr;
	assign wr = psel && penable && pready && pwrite && paddr == 12'h000;
	// Shadow of the programmed comma, snooped from the bus
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn) pat_reg <= 10'h0FA;
		else if (wr) pat_reg <= pwdata[9:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		!pready ##1 pready;
	endsequence
	AST_APB_WAIT: assert property (s_setup |=> s_answer)
		else $error("pready not after one wait state");
	AST_TX_PASS: assert property (
		!xgmii_txc[0] || xgmii_txd[7:0] inside {8'h9C, 8'hFB, 8'hFD}
		|=> tx_code[7:0] == $past(xgmii_txd[7:0]))
		else $error("tx byte not passed");
	AST_TX_ERR: assert property (
		xgmii_txc[0] && !(xgmii_txd[7:0] inside {8'h07, 8'h9C, 8'hFB, 8'hFD})
		|=> tx_code[7:0] == 8'hFE) else $error("tx error code wrong");
	AST_TX_IDLE: assert property (
		xgmii_txc[0] && xgmii_txd[7:0] == 8'h07
		|=> tx_code[7:0] inside {8'h1C, 8'h7C, 8'hBC})
		else $error("idle code wrong");
	AST_TX_COL: assert property (
		xgmii_txc[3:0] == 4'hF && xgmii_txd[31:0] == 32'h07070707
		|=> tx_code[31:0] == {4{tx_code[7:0]}})
		else $error("idle column not uniform");
	AST_RX_MAP: assert property (
		rx_decerr[0] || !rx_deck[0] |=> {xgmii_rxc[0], xgmii_rxd[7:0]} ==
		($past(rx_decerr[0]) ? 9'h1FE : {1'b0, $past(rx_dec[7:0])}))
		else $error("rx map wrong");
	AST_SEEN: assert property (!$past(wr) |-> comma_seen[0] ==
		(rx_aligned[9:0] == pat_reg || rx_aligned[9:0] == ~pat_reg))
		else $error("comma seen wrong");
	AST_LOCK_DROP: assert property (rx_reset |=> lane_locked == 8'h00)
		else $error("locked during rx reset");
	AST_LOCK_PAIR: assert property (lane_locked[3:0] == lane_locked[7:4])
		else $error("byte locks differ");
	AST_LOCK_RISE: assert property ($rose(lane_locked[0]) |->
		$past(rx_deck[0] && rx_dec[7:0] == 8'hBC ||
		rx_deck[4] && rx_dec[39:32] == 8'hBC)) else $error("lock without comma");
endmodule
bind xcmwa_top xcmwa_asserts i_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .xgmii_txd, .xgmii_txc, .tx_code,
	.rx_aligned, .comma_seen, .rx_dec, .rx_deck, .rx_decerr, .rx_reset,
	.xgmii_rxd, .xgmii_rxc, .lane_locked);
`default_nettype wire

// [bench/xcmwa_partner.sv]
// Remote lane partner: raw serial words and decoded stream
`timescale 1ns/1ps
`default_nettype none
module xcmwa_partner (
	input wire logic pclk,
	input wire logic sig_on,
	input wire logic err_on,
	input wire logic [4:0] slip,
	output logic [79:0] rx_raw,
	output logic [63:0] rx_dec,
	output logic [7:0] rx_deck,
	output logic [7:0] rx_decerr,
	output logic [3:0] sig_detect
);
	logic [39:0] s2;
	logic [7:0] d;
	logic kh;
	// Valid special bytes only; invalid groups are flagged only while err_on is high
	logic [7:0] ktab [8] = '{8'h1C, 8'h7C, 8'hBC, 8'h9C, 8'hFB, 8'hFD,
		8'hF7, 8'hFE};
	// Comma then a run-free group, so no false comma at any offset
	assign s2 = {2{10'h2AA, 10'h0FA}};
	initial {rx_raw, rx_dec, rx_deck, rx_decerr, sig_detect} = '0;
	always @(posedge pclk) begin
		d = 8'($urandom);
		kh = 1'($urandom);
		sig_detect <= {4{sig_on}};
		rx_raw <= sig_on ? {4{s2[slip+:20]}} : {$urandom, $urandom, 16'($urandom)};
		rx_dec <= {{4{kh ? ktab[d[2:0]] : d}}, {4{8'hBC}}};
		rx_deck <= {{4{kh}}, 4'hF};
		rx_decerr <= {8{err_on}};
	end
endmodule
`default_nettype wire

// [bench/test_xaui_code_map_word_align.sv]
// Testbench with reference model for the XAUI front end
`timescale 1ns/1ps
`default_nettype none
module test_xaui_code_map_word_align;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic pready, pslverr, se, sig_on = 0, err_on = 0, rx_reset = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [63:0] xgmii_txd = 0, tx_code, rx_dec, xgmii_rxd, ptxd, prxd, b;
	logic [7:0] xgmii_txc = 0, tx_kflag, rx_deck, rx_decerr, comma_seen, c;
	logic [7:0] xgmii_rxc, lane_locked, ptxc, prxk, prxe, e;
	logic [7:0] tbl [5] = '{8'h07, 8'h9C, 8'hFB, 8'hFD, 8'hFE};
	logic [79:0] rx_raw, rx_aligned;
	logic [3:0] comma_align_en = 0, sig_detect;
	logic [4:0] slip = 0;
	integer err_total = 0, check_count = 0, cyc = 0, acnt = 0, i, j;
	always #12.5 pclk = ~pclk;
	xcmwa_top i_xcmwa_top (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .xgmii_txd,
		.xgmii_txc, .tx_code, .tx_kflag, .rx_raw, .comma_align_en,
		.rx_aligned, .comma_seen, .rx_dec, .rx_deck, .rx_decerr, .rx_reset,
		.sig_detect, .xgmii_rxd, .xgmii_rxc, .lane_locked);
	xcmwa_partner i_xcmwa_partner (.pclk, .sig_on, .err_on, .slip, .rx_raw,
		.rx_dec, .rx_deck, .rx_decerr, .sig_detect);
	task chk(input string n, input [79:0] x, input [79:0] g);
		check_count++;
		if (g !== x) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, x, g);
		end
	endtask
	task conclude;
		if (err_total == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		{rd, se} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
	endtask
	function [8:0] rxm(input [7:0] v, input k, input x);
		if (x) rxm = 9'h1FE;
		else if (!k) rxm = {1'b0, v};
		else if (v inside {8'h1C, 8'h7C, 8'hBC}) rxm = 9'h107;
		else if (v inside {8'h9C, 8'hFB, 8'hFD}) rxm = {1'b1, v};
		else rxm = 9'h1FE;
	endfunction
	function [7:0] txm(input [7:0] v, input k);
		if (!k || v inside {8'h9C, 8'hFB, 8'hFD}) txm = v;
		else if (v == 8'h07) txm = 8'hBC;
		else txm = 8'hFE;
	endfunction
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			conclude;
		end
		if (cyc > 8) begin
			chk("kflag", ptxc, tx_kflag);
			for (i = 0; i < 8; i++) begin
				e = tx_code[i*8+:8];
				if (ptxc[i/4*4+:4] == 4'hF && ptxd[i/4*32+:32] == 32'h07070707) begin
					acnt += e == 8'h7C;
					chk("idle", 1, e inside {8'h1C, 8'h7C, 8'hBC});
				end else chk("tx", txm(ptxd[i*8+:8], ptxc[i]), e);
				chk("rx", rxm(prxd[i*8+:8], prxk[i], prxe[i]),
					{xgmii_rxc[i], xgmii_rxd[i*8+:8]});
			end
		end
		{ptxd, ptxc, prxd, prxk, prxe} = {xgmii_txd, xgmii_txc, rx_dec,
			rx_deck, rx_decerr};
	end
	initial begin
		void'($urandom(59708));
		repeat (6) @(posedge pclk);
		presetn <= 1;
		apb(0, 12'h000, 0);
		chk("ctrl", 32'h000100FA, rd);
		chk("slverr", 0, se);
		apb(0, 12'h008, 0);
		chk("slverr", 1, se);
		apb(1, 12'h004, 0);
		chk("slverr", 1, se);
		repeat (300) begin
			@(posedge pclk);
			for (j = 0; j < 8; j++) begin
				c[j] = $urandom;
				b[j*8+:8] = c[j] & $urandom ? tbl[$urandom % 5] : $urandom;
			end
			{xgmii_txc, xgmii_txd} <= {c, b};
		end
		{xgmii_txc, xgmii_txd} <= {8'hFF, {8{8'h07}}};
		repeat (100) @(posedge pclk);
		chk("a_count", 1, acnt > 2);
		sig_on <= 1;
		repeat (10) @(posedge pclk);
		chk("lock", 0, lane_locked);
		rx_reset <= 0;
		repeat (5) @(posedge pclk);
		chk("lock", 0, lane_locked);
		@(posedge pclk);
		chk("lock", 8'hFF, lane_locked);
		err_on <= 1;
		repeat (3) @(posedge pclk);
		err_on <= 0;
		sig_on <= 0;
		repeat (6) @(posedge pclk);
		chk("lock", 0, lane_locked);
		sig_on <= 1;
		repeat (10) @(posedge pclk);
		apb(0, 12'h004, 0);
		chk("status", 32'h0000F0FF, rd);
		slip <= 5'd7;
		repeat (4) @(posedge pclk);
		chk("seen", 0, comma_seen);
		comma_align_en <= 4'hF;
		repeat (6) @(posedge pclk);
		chk("aligned", {4{10'h2AA, 10'h0FA}}, rx_aligned);
		chk("seen", 8'h55, comma_seen);
		apb(1, 12'h000, 32'h00010305);
		repeat (3) @(posedge pclk);
		chk("seen", 8'h55, comma_seen);
		apb(1, 12'h000, 32'h000102AA);
		repeat (3) @(posedge pclk);
		chk("seen", 8'hAA, comma_seen);
		apb(1, 12'h000, 32'h000000FA);
		repeat (2) @(posedge pclk);
		chk("idle_off", {8{8'hBC}}, tx_code);
		apb(0, 12'h000, 0);
		chk("ctrl", 32'h000000FA, rd);
		rx_reset <= 1;
		repeat (2) @(posedge pclk);
		chk("lock", 0, lane_locked);
		conclude;
	end
endmodule
`default_nettype wire
